// file: rtl/dtf_pkg.sv
// package: port map, status layout, timing counts and carrier types of the transfer block
package dtf_pkg;
   // ------------------------------------------------------------
   // i/o port addresses
   // ------------------------------------------------------------
   localparam logic [15:0] ADDR_MARK_TRIGGER_PORT = 16'h3030;
   localparam logic [15:0] CONTROLLER_STATUS_PORT = 16'h8000;
   localparam logic [15:0] FORMAT_START_UNIT_PORT = 16'h8018;
   localparam logic [15:0] SERIAL_BUFFER_PORT = 16'h8028;

   // ------------------------------------------------------------
   // status word layout and reset values
   // ------------------------------------------------------------
   localparam int STAT_INDEX_BIT = 15;
   localparam int STAT_FORMAT_BIT = 2;
   localparam int STAT_XFER_BIT = 1;
   localparam int STAT_TIMEOUT_BIT = 0;
   localparam int UNIT_CODE_LSB = 3;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] READ_BUFFER_RESET = 16'h0000;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int BYTE_TIME_NS = 800;
   localparam int AM_PULSE_NS = 800;
   localparam int GAP_BYTE_TIMES = 11;
   localparam int SEARCH_REVOLUTIONS = 2;
   // least times: round up to whole cycles
   localparam int BYTE_CLKS = (BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AM_PULSE_CLKS = (AM_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // buffering
   // ------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int WBUF_DEPTH = 4;

   // ------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } dtf_io_req_t;

   typedef struct packed {
      logic index_n;
      logic sector_n;
      logic mwait0_n;
      logic mwait1_n;
   } dtf_pins_t;
endpackage

// file: rtl/dtf_fifo.sv
// module: write buffer fifo between the processor port and the serializer
`timescale 1ns/1ns
module dtf_fifo #(
   parameter int W = 16,
   parameter int D = 4
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } dtf_fifo_state_t;

   dtf_fifo_state_t st_ff;
   dtf_fifo_state_t nxt_st;
   logic push;
   logic pop;

   assign in_ready_o = (st_ff.count != (AW+1)'(D));
   assign out_valid_o = (st_ff.count != '0);
   assign out_data_o = st_ff.mem[st_ff.rd_ptr];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb
   begin
      nxt_st = st_ff;
      if (push)
      begin
         nxt_st.mem[st_ff.wr_ptr] = in_data_i;
         nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(D-1)) ? '0 : st_ff.wr_ptr + 1'b1;
      end
      if (pop)
      begin
         nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(D-1)) ? '0 : st_ff.rd_ptr + 1'b1;
      end
      nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         st_ff <= '0;
      else if (ce_i)
         st_ff <= nxt_st;
   end
endmodule

// file: rtl/dtf_core.sv
// module: word transfer ready handshake and first format pass sequencing
`timescale 1ns/1ns
module dtf_core #(
   parameter int BYTE_CLKS = dtf_pkg::BYTE_CLKS,
   parameter int AM_PULSE_CLKS = dtf_pkg::AM_PULSE_CLKS,
   parameter int WBUF_DEPTH = dtf_pkg::WBUF_DEPTH
) (
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic CE_I,
   input wire dtf_pkg::dtf_io_req_t IO_REQ_I,
   output logic [15:0] IO_RDATA_O,
   output logic READY_O,
   input wire dtf_pkg::dtf_pins_t PINS_I,
   input wire logic RW_GATE_I,
   input wire logic SEARCH_I,
   input wire logic SYNC_FOUND_I,
   input wire logic BIT_RING_ZERO_I,
   input wire logic HARD_SECTOR_I,
   input wire logic FORMAT_END_I,
   input wire logic [15:0] DES_WORD_I,
   input wire logic DES_VALID_I,
   output logic [15:0] SER_WORD_O,
   output logic SER_VALID_O,
   input wire logic SER_READY_I,
   output logic ZERO_FILL_O,
   output logic WRITE_GATE_FLOP_O,
   output logic FORMAT_O,
   output logic DRIVE_WRITE_GATE_O,
   output logic [1:0] UNIT_O,
   output logic WRITE_ADDRESS_MARK_O,
   output logic ADDRESS_MARK_ENABLE_O,
   output logic WRITE_TRANSFER_LINE_O,
   output logic TRANSFER_ENABLE_LINE_O,
   output logic TIMEOUT_O
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] pin_s1;
      logic [3:0] pin_s2;
      logic index_prev;
      logic sector_prev;
      logic ready;
      logic xsync;
      logic xfer_en;
      logic timeout;
      logic [1:0] rev_cnt;
      logic fmt;
      logic wgate_flop;
      logic drive_wgate;
      logic [1:0] unit;
      logic idx_latch;
      logic sector_started;
      logic [7:0] am_cnt;
      logic wr_am;
      logic gap_run;
      logic [3:0] gap_bytes;
      logic [7:0] byte_div;
      logic wr_xfer;
      logic [15:0] rdata;
      logic [15:0] rbuf;
      logic zero_fill;
   } dtf_state_t;

   dtf_state_t st_ff;
   dtf_state_t nxt_st;

   logic fifo_in_ready;
   logic [15:0] fifo_out_data;
   logic fifo_out_valid;

   logic index_now;
   logic sector_now;
   logic index_rise;
   logic sector_rise;
   logic wait_ok;
   logic buf_hit;
   logic buf_wr;
   logic buf_rd;
   logic strobe;
   logic done;
   logic push;
   logic status_rd;
   logic fmt_wr;
   logic mark_wr;
   logic mark_fire;
   logic gate_open;
   logic latch_ok;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   always_comb
   begin
      // pin order in the sync vector: index, sector, wait0, wait1
      index_now = ~st_ff.pin_s2[3];
      sector_now = ~st_ff.pin_s2[2];
      index_rise = index_now & ~st_ff.index_prev;
      sector_rise = sector_now & ~st_ff.sector_prev;
      // either connector pulling its wait line low stalls the processor
      wait_ok = st_ff.pin_s2[1] & st_ff.pin_s2[0];
      buf_hit = (IO_REQ_I.addr == dtf_pkg::SERIAL_BUFFER_PORT);
      buf_wr = buf_hit & IO_REQ_I.wr;
      buf_rd = buf_hit & IO_REQ_I.rd;
      strobe = buf_wr | buf_rd;
      // a write needs buffer room; otherwise the word is not taken and the strobe waits
      done = st_ff.ready & (buf_rd | (buf_wr & fifo_in_ready));
      push = done & buf_wr;
      status_rd = IO_REQ_I.rd & (IO_REQ_I.addr == dtf_pkg::CONTROLLER_STATUS_PORT);
      fmt_wr = IO_REQ_I.wr & (IO_REQ_I.addr == dtf_pkg::FORMAT_START_UNIT_PORT);
      mark_wr = IO_REQ_I.wr & (IO_REQ_I.addr == dtf_pkg::ADDR_MARK_TRIGGER_PORT);
      // soft sectored: processor triggers; hard sectored: first sector pulse after index
      mark_fire = st_ff.fmt & st_ff.idx_latch & ~HARD_SECTOR_I & mark_wr;
      gate_open = st_ff.fmt & st_ff.idx_latch & HARD_SECTOR_I & ~st_ff.sector_started & sector_rise;
      // sync flop stands high while transfer enable is low, strobe then decides
      latch_ok = st_ff.xfer_en ? st_ff.xsync : ~strobe;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.pin_s1 = {PINS_I.index_n, PINS_I.sector_n, PINS_I.mwait0_n, PINS_I.mwait1_n};
      nxt_st.pin_s2 = st_ff.pin_s1;
      nxt_st.index_prev = index_now;
      nxt_st.sector_prev = sector_now;

      // transfer enable: sync found or format write transfer; ends with the gate
      if (!RW_GATE_I)
         nxt_st.xfer_en = 1'b0;
      else if (SYNC_FOUND_I | st_ff.wr_xfer)
         nxt_st.xfer_en = 1'b1;

      // transfer sync flop: set on bit ring zero, cleared the clock after a word
      if (!st_ff.xfer_en)
         nxt_st.xsync = 1'b1;
      else if (BIT_RING_ZERO_I)
         nxt_st.xsync = 1'b1;
      else if (done)
         nxt_st.xsync = 1'b0;
      if (st_ff.xfer_en & done & ~BIT_RING_ZERO_I)
         nxt_st.xsync = 1'b0;

      // search timeout counts index pulses while searching
      if (!SEARCH_I)
      begin
         nxt_st.rev_cnt = 2'h0;
         nxt_st.timeout = 1'b0;
      end
      else if (index_rise & ~st_ff.timeout)
      begin
         nxt_st.rev_cnt = st_ff.rev_cnt + 2'h1;
         if (st_ff.rev_cnt == 2'(dtf_pkg::SEARCH_REVOLUTIONS - 1))
            nxt_st.timeout = 1'b1;
      end

      // ready: timeout forces it; search, wait line or closed gate block it
      nxt_st.ready = st_ff.timeout
         | (~SEARCH_I & wait_ok & RW_GATE_I & latch_ok & ~done & (~buf_wr | fifo_in_ready));

      // format start
      if (fmt_wr)
      begin
         nxt_st.fmt = 1'b1;
         nxt_st.wgate_flop = 1'b1;
         nxt_st.drive_wgate = 1'b1;
         nxt_st.unit = IO_REQ_I.wdata[dtf_pkg::UNIT_CODE_LSB +: 2];
         nxt_st.idx_latch = index_rise;
         nxt_st.sector_started = 1'b0;
         nxt_st.wr_xfer = 1'b0;
         nxt_st.gap_run = 1'b0;
         nxt_st.am_cnt = 8'h00;
         nxt_st.wr_am = 1'b0;
      end
      else if (FORMAT_END_I)
      begin
         // one track per command: the pass closes and waits for a new start
         nxt_st.fmt = 1'b0;
         nxt_st.wgate_flop = 1'b0;
         nxt_st.drive_wgate = 1'b0;
         nxt_st.wr_xfer = 1'b0;
         nxt_st.gap_run = 1'b0;
      end
      else
      begin
         if (st_ff.fmt & index_rise)
            nxt_st.idx_latch = 1'b1;

         // address mark one-shot, width fixed by its own count
         if (mark_fire)
         begin
            nxt_st.am_cnt = 8'(AM_PULSE_CLKS);
            nxt_st.wr_am = 1'b1;
         end
         else if (st_ff.am_cnt > 8'h01)
            nxt_st.am_cnt = st_ff.am_cnt - 8'h01;
         else
         begin
            nxt_st.am_cnt = 8'h00;
            nxt_st.wr_am = 1'b0;
         end

         // gap counter from the mark or the sector pulse
         if (mark_fire | gate_open)
         begin
            nxt_st.sector_started = st_ff.sector_started | gate_open;
            nxt_st.gap_run = 1'b1;
            nxt_st.gap_bytes = 4'(dtf_pkg::GAP_BYTE_TIMES);
            nxt_st.byte_div = 8'(BYTE_CLKS - 1);
            nxt_st.wr_xfer = 1'b0;
         end
         else if (st_ff.gap_run)
         begin
            if (st_ff.byte_div != 8'h00)
               nxt_st.byte_div = st_ff.byte_div - 8'h01;
            else
            begin
               nxt_st.byte_div = 8'(BYTE_CLKS - 1);
               nxt_st.gap_bytes = st_ff.gap_bytes - 4'h1;
               if (st_ff.gap_bytes == 4'h1)
               begin
                  nxt_st.gap_run = 1'b0;
                  nxt_st.wr_xfer = 1'b1;
               end
            end
         end
      end

      // register port reads are answered one cycle later
      if (status_rd)
      begin
         nxt_st.rdata = dtf_pkg::STATUS_RESET;
         nxt_st.rdata[dtf_pkg::STAT_INDEX_BIT] = st_ff.idx_latch;
         nxt_st.rdata[dtf_pkg::STAT_FORMAT_BIT] = st_ff.fmt;
         nxt_st.rdata[dtf_pkg::STAT_XFER_BIT] = st_ff.xfer_en;
         nxt_st.rdata[dtf_pkg::STAT_TIMEOUT_BIT] = st_ff.timeout;
      end
      else if (done & buf_rd)
         nxt_st.rdata = st_ff.rbuf;

      // deserializer word lands in the read buffer; a late drain loses the older word
      if (DES_VALID_I)
         nxt_st.rbuf = DES_WORD_I;
      nxt_st.zero_fill = nxt_st.fmt & ~nxt_st.idx_latch;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         st_ff <= '0;
         st_ff.pin_s1 <= 4'hf;
         st_ff.pin_s2 <= 4'hf;
         st_ff.xsync <= 1'b1;
         st_ff.rdata <= dtf_pkg::STATUS_RESET;
         st_ff.rbuf <= dtf_pkg::READ_BUFFER_RESET;
      end
      else if (CE_I)
      begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // write buffer
   // ------------------------------------------------------------
   dtf_fifo #(
      .W(dtf_pkg::WORD_W),
      .D(WBUF_DEPTH)
   ) u_wbuf (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .ce_i(CE_I),
      .in_data_i(IO_REQ_I.wdata),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(SER_READY_I & ~st_ff.zero_fill)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // in a format pass the serializer sees zeros, not buffered words, until index arrives
   assign SER_WORD_O = st_ff.zero_fill ? 16'h0000 : fifo_out_data;
   assign SER_VALID_O = fifo_out_valid & ~st_ff.zero_fill;
   assign ZERO_FILL_O = st_ff.zero_fill;
   assign IO_RDATA_O = st_ff.rdata;
   assign READY_O = st_ff.ready;
   assign WRITE_GATE_FLOP_O = st_ff.wgate_flop;
   assign FORMAT_O = st_ff.fmt;
   assign DRIVE_WRITE_GATE_O = st_ff.drive_wgate;
   assign UNIT_O = st_ff.unit;
   assign WRITE_ADDRESS_MARK_O = st_ff.wr_am;
   assign ADDRESS_MARK_ENABLE_O = st_ff.wr_am;
   assign WRITE_TRANSFER_LINE_O = st_ff.wr_xfer;
   assign TRANSFER_ENABLE_LINE_O = st_ff.xfer_en;
   assign TIMEOUT_O = st_ff.timeout;
endmodule

// file: verification/dtf_core_monitor.sv
// checker: port-level assertions for the transfer handshake and format sequencing
`timescale 1ns/1ns
module dtf_core_monitor #(
   parameter int BYTE_CLKS = dtf_pkg::BYTE_CLKS,
   parameter int AM_PULSE_CLKS = dtf_pkg::AM_PULSE_CLKS
) (
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire dtf_pkg::dtf_io_req_t IO_REQ_I,
   input wire logic READY_O,
   input wire dtf_pkg::dtf_pins_t PINS_I,
   input wire logic RW_GATE_I,
   input wire logic SEARCH_I,
   input wire logic SYNC_FOUND_I,
   input wire logic BIT_RING_ZERO_I,
   input wire logic FORMAT_END_I,
   input wire logic [15:0] SER_WORD_O,
   input wire logic SER_VALID_O,
   input wire logic SER_READY_I,
   input wire logic ZERO_FILL_O,
   input wire logic WRITE_GATE_FLOP_O,
   input wire logic FORMAT_O,
   input wire logic DRIVE_WRITE_GATE_O,
   input wire logic [1:0] UNIT_O,
   input wire logic WRITE_ADDRESS_MARK_O,
   input wire logic ADDRESS_MARK_ENABLE_O,
   input wire logic WRITE_TRANSFER_LINE_O,
   input wire logic TRANSFER_ENABLE_LINE_O,
   input wire logic TIMEOUT_O
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // gap window kept loose: the exact launch cycle of the counter is a design choice
   localparam int GAP_LO = 11 * BYTE_CLKS - 3;
   localparam int GAP_HI = 11 * BYTE_CLKS + 3;
   logic [7:0] am_cnt_ff;
   logic buf_rq;
   logic fmt_wr;
   assign buf_rq = (IO_REQ_I.wr | IO_REQ_I.rd) && IO_REQ_I.addr == dtf_pkg::SERIAL_BUFFER_PORT;
   assign fmt_wr = IO_REQ_I.wr && IO_REQ_I.addr == dtf_pkg::FORMAT_START_UNIT_PORT;
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         am_cnt_ff <= 8'h00;
      else
         am_cnt_ff <= WRITE_ADDRESS_MARK_O ? am_cnt_ff + 8'h01 : 8'h00;
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   // a blocking condition with timeout quiet over two samples
   sequence calm_s(c);
      c && !TIMEOUT_O ##1 !TIMEOUT_O;
   endsequence
   // ring pulse with the path open, still open a clock later: a falling gate ends the handshake
   sequence ring_open_s;
      TRANSFER_ENABLE_LINE_O && BIT_RING_ZERO_I && RW_GATE_I && !SEARCH_I && SER_READY_I
         && PINS_I.mwait0_n && PINS_I.mwait1_n ##1 RW_GATE_I && !SEARCH_I;
   endsequence
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   timeout_ready_a: assert property (TIMEOUT_O && SEARCH_I |=> READY_O) else $error("timeout without ready");
   search_hold_a: assert property (calm_s(SEARCH_I) |-> !READY_O) else $error("ready during search");
   gate_off_a: assert property (calm_s(!RW_GATE_I) |-> !READY_O) else $error("ready with gate low");
   strobe_drop_a: assert property (buf_rq && READY_O && !SEARCH_I |-> ##[1:2] !READY_O)
      else $error("ready held after buffer strobe");
   ring_ready_a: assert property (ring_open_s |-> ##[0:2] READY_O) else $error("no ready after ring");
   format_start_a: assert property (fmt_wr && !FORMAT_END_I |=> FORMAT_O && WRITE_GATE_FLOP_O
      && DRIVE_WRITE_GATE_O && UNIT_O == $past(IO_REQ_I.wdata[4:3])) else $error("format start lines wrong");
   mark_width_a: assert property ($fell(WRITE_ADDRESS_MARK_O) |-> am_cnt_ff == 8'(AM_PULSE_CLKS))
      else $error("mark pulse width wrong");
   mark_mirror_a: assert property (ADDRESS_MARK_ENABLE_O == WRITE_ADDRESS_MARK_O) else $error("mark enable");
   gap_count_a: assert property ($rose(WRITE_ADDRESS_MARK_O) |-> ##[GAP_LO:GAP_HI] WRITE_TRANSFER_LINE_O)
      else $error("write transfer late");
   xfer_arm_a: assert property (WRITE_TRANSFER_LINE_O && RW_GATE_I |=> TRANSFER_ENABLE_LINE_O)
      else $error("transfer enable not armed");
   sync_arm_a: assert property (SYNC_FOUND_I && RW_GATE_I |-> ##[1:2] TRANSFER_ENABLE_LINE_O)
      else $error("sync did not arm transfer");
   zero_fill_a: assert property (ZERO_FILL_O |-> !SER_VALID_O && SER_WORD_O == 16'h0000)
      else $error("data during zero fill");
endmodule
bind dtf_core dtf_core_monitor #(.BYTE_CLKS(BYTE_CLKS), .AM_PULSE_CLKS(AM_PULSE_CLKS)) u_dtf_core_monitor (
   .CLK_I(CLK_I), .RESET_I(RESET_I), .IO_REQ_I(IO_REQ_I), .READY_O(READY_O), .PINS_I(PINS_I),
   .RW_GATE_I(RW_GATE_I), .SEARCH_I(SEARCH_I), .SYNC_FOUND_I(SYNC_FOUND_I), .BIT_RING_ZERO_I(BIT_RING_ZERO_I),
   .FORMAT_END_I(FORMAT_END_I), .SER_WORD_O(SER_WORD_O), .SER_VALID_O(SER_VALID_O), .SER_READY_I(SER_READY_I),
   .ZERO_FILL_O(ZERO_FILL_O), .WRITE_GATE_FLOP_O(WRITE_GATE_FLOP_O), .FORMAT_O(FORMAT_O),
   .DRIVE_WRITE_GATE_O(DRIVE_WRITE_GATE_O), .UNIT_O(UNIT_O), .WRITE_ADDRESS_MARK_O(WRITE_ADDRESS_MARK_O),
   .ADDRESS_MARK_ENABLE_O(ADDRESS_MARK_ENABLE_O), .WRITE_TRANSFER_LINE_O(WRITE_TRANSFER_LINE_O),
   .TRANSFER_ENABLE_LINE_O(TRANSFER_ENABLE_LINE_O), .TIMEOUT_O(TIMEOUT_O));

// file: verification/dtf_iop_model.sv
// model: i/o processor that strobes the buffer, status and format ports
`timescale 1ns/1ns
module dtf_iop_model (
   input wire logic clk_i,
   input wire logic ready_i,
   input wire logic [15:0] rdata_i,
   output dtf_pkg::dtf_io_req_t req_o,
   output logic done_o,
   output logic [15:0] data_o
);
   initial
   begin
      req_o = '0;
      done_o = 1'b0;
      data_o = 16'h0000;
   end
   // idle sets how slowly the processor issues its next request
   task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wd, input int idle);
      int n;
      n = 0;
      repeat (idle + 1) @(posedge clk_i);
      #1;
      req_o = '{addr: addr, wdata: wd, wr: wr, rd: !wr};
      // ready is looked at between edges, where it stands for the next edge: the word moves there
      while (addr == dtf_pkg::SERIAL_BUFFER_PORT && ready_i !== 1'b1 && n < 3000)
      begin
         n++;
         @(posedge clk_i);
         #1;
      end
      @(posedge clk_i);
      #1;
      // released lines show the inverse so a stale value never looks valid
      req_o = '{addr: ~addr, wdata: ~wd, wr: 1'b0, rd: 1'b0};
      data_o = rdata_i;
      @(posedge clk_i);
      #1;
      done_o = !wr;
      @(posedge clk_i);
      #1;
      done_o = 1'b0;
   endtask
endmodule

// file: verification/disk_transfer_handshake_format_tb.sv
// testbench: handshake, buffering and first format pass of the transfer block
`timescale 1ns/1ns
module disk_transfer_handshake_format_tb;
   logic clk, rst, ce, ready, gate, search, sync_found, brz, brz_on, hard, fmt_end, des_valid, ser_valid, ser_ready;
   logic zero_fill, wgf, fmt, dwg, wam, ame, wtl, xen, tmo, done;
   logic [15:0] rdata, des_word, ser_word, data, w;
   logic [1:0] unit;
   dtf_pkg::dtf_io_req_t req;
   dtf_pkg::dtf_pins_t pins;
   logic [15:0] ser_q[$];
   logic [15:0] rd_q[$];
   int num_errors, compares, i, n;
   int cyc = 0;
   dtf_core #(.BYTE_CLKS(2), .AM_PULSE_CLKS(2)) u_dtf_core (.CLK_I(clk), .RESET_I(rst),
      .CE_I(ce), .IO_REQ_I(req), .IO_RDATA_O(rdata), .READY_O(ready), .PINS_I(pins), .RW_GATE_I(gate),
      .SEARCH_I(search), .SYNC_FOUND_I(sync_found), .BIT_RING_ZERO_I(brz), .HARD_SECTOR_I(hard),
      .FORMAT_END_I(fmt_end), .DES_WORD_I(des_word), .DES_VALID_I(des_valid), .SER_WORD_O(ser_word),
      .SER_VALID_O(ser_valid), .SER_READY_I(ser_ready), .ZERO_FILL_O(zero_fill), .WRITE_GATE_FLOP_O(wgf),
      .FORMAT_O(fmt), .DRIVE_WRITE_GATE_O(dwg), .UNIT_O(unit), .WRITE_ADDRESS_MARK_O(wam),
      .ADDRESS_MARK_ENABLE_O(ame), .WRITE_TRANSFER_LINE_O(wtl), .TRANSFER_ENABLE_LINE_O(xen), .TIMEOUT_O(tmo));
   dtf_iop_model u_dtf_iop_model (.clk_i(clk), .ready_i(ready), .rdata_i(rdata), .req_o(req), .done_o(done),
      .data_o(data));
   // ------------------------------------------------------------
   // clock, ring pulses, hang limit and result watcher
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic complete_run();
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      brz <= brz_on && cyc[2:0] == 3'h0;
      if (cyc == 6000)
      begin
         num_errors++;
         complete_run();
      end
   end
   // results looked at where settled, half a period before the edge that takes them
   always @(negedge clk)
   begin
      if (ser_valid === 1'b1 && ser_ready === 1'b1)
         check(ser_word, ser_q.size() > 0 ? ser_q.pop_front() : 16'hxxxx);
      if (done === 1'b1)
         check(data, rd_q.size() > 0 ? rd_q.pop_front() : 16'hxxxx);
   end
   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic index_pulse(input int s);
      pins[s] = 1'b0;
      step(4);
      pins[s] = 1'b1;
      step(8);
   endtask
   task automatic write_words(input int k);
      for (int j = 0; j < k; j++)
      begin
         w = 16'($urandom);
         ser_q.push_back(w);
         u_dtf_iop_model.access(1'b1, dtf_pkg::SERIAL_BUFFER_PORT, w, j % 3);
      end
   endtask
   initial
   begin
      void'($urandom(19));
      {rst, gate, search, sync_found, brz_on, hard, fmt_end, des_valid, ser_ready} = 9'h100;
      ce = 1'b1;
      pins = 4'hf;
      des_word = 16'h0000;
      step(4);
      rst = 1'b0;
      gate = 1'b1;
      step(3);
      check(16'(ready), 16'h0001);
      brz_on = 1'b1;
      sync_found = 1'b1;
      step(1);
      sync_found = 1'b0;
      step(2);
      check(16'(xen), 16'h0001);
      // five words against a stalled four-deep buffer: the fifth must wait
      fork
         write_words(5);
      join_none
      step(120);
      check(16'(ready), 16'h0000);
      ser_ready = 1'b1;
      wait fork;
      step(20);
      check(16'(ser_q.size()), 16'h0000);
      for (i = 0; i < 2; i++)
      begin
         des_word = 16'($urandom);
         des_valid = 1'b1;
         rd_q.push_back(des_word);
         step(1);
         des_valid = 1'b0;
         u_dtf_iop_model.access(1'b0, dtf_pkg::SERIAL_BUFFER_PORT, 16'h0000, i);
      end
      gate = 1'b0;
      step(3);
      check(16'({ready, xen}), 16'h0000);
      gate = 1'b1;
      step(3);
      check(16'(ready), 16'h0001);
      for (i = 0; i < 2; i++)
      begin
         pins[i] = 1'b0;
         step(4);
         check(16'(ready), 16'h0000);
         pins[i] = 1'b1;
         step(4);
         check(16'(ready), 16'h0001);
      end
      // clock enable low freezes the synchronisers: a wait pulse must not reach ready
      ce = 1'b0;
      pins[1] = 1'b0;
      step(4);
      check(16'(ready), 16'h0001);
      pins[1] = 1'b1;
      step(1);
      ce = 1'b1;
      step(4);
      check(16'(ready), 16'h0001);
      search = 1'b1;
      step(3);
      check(16'(ready), 16'h0000);
      index_pulse(3);
      check(16'(tmo), 16'h0000);
      index_pulse(3);
      check(16'({tmo, ready}), 16'h0003);
      search = 1'b0;
      step(3);
      check(16'(tmo), 16'h0000);
      for (i = 0; i < 4; i++)
      begin
         hard = (i == 3);
         u_dtf_iop_model.access(1'b1, dtf_pkg::FORMAT_START_UNIT_PORT, 16'h00c0 + 16'(i * 8), 0);
         check(16'({unit, zero_fill, fmt, wgf, dwg}), 16'(i * 16 + 15));
         rd_q.push_back(16'h0004);
         u_dtf_iop_model.access(1'b0, dtf_pkg::CONTROLLER_STATUS_PORT, 16'h0000, 0);
         index_pulse(3);
         rd_q.push_back(16'h8004);
         u_dtf_iop_model.access(1'b0, dtf_pkg::CONTROLLER_STATUS_PORT, 16'h0000, 0);
         check(16'(zero_fill), 16'h0000);
         // sync byte preloaded before the mark, ahead of the roughly eleven byte times of gap that follow the mark, or the sector pulse when hard sectored
         ser_q.push_back(16'h0019);
         u_dtf_iop_model.access(1'b1, dtf_pkg::SERIAL_BUFFER_PORT, 16'h0019, 16);
         u_dtf_iop_model.access(1'b1, dtf_pkg::ADDR_MARK_TRIGGER_PORT, 16'($urandom), 0);
         if (hard)
         begin
            step(6);
            check(16'(wam), 16'h0000);
            index_pulse(2);
         end
         n = 0;
         while (wtl !== 1'b1 && n < 200)
         begin
            step(1);
            n++;
         end
         check(16'(n > 6 && n < 30), 16'h0001);
         step(2);
         check(16'(xen), 16'h0001);
         fmt_end = 1'b1;
         step(1);
         fmt_end = 1'b0;
         step(2);
         check(16'({fmt, wtl}), 16'h0000);
         gate = 1'b0;
         step(2);
         gate = 1'b1;
         step(3);
      end
      // unmapped read leaves the last read data standing
      rd_q.push_back(16'h8004);
      u_dtf_iop_model.access(1'b0, 16'h1234, 16'h0000, 0);
      step(3);
      check(16'(rd_q.size() + ser_q.size()), 16'h0000);
      complete_run();
   end
endmodule
